// file: rtl/dcr_pkg.sv
// Constants shared by the DMA control register block and its helpers
package dcr_pkg;

    // ------------------------------------------------------------------
    // Register indices as printed; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [31:0] IDX_CTL_RESET   = 32'h0b000040;
    localparam logic [31:0] IDX_SEQ_IDLE    = 32'h0b000042;
    localparam logic [31:0] IDX_SEQ_ENABLE  = 32'h0b000044;
    localparam logic [31:0] IDX_CH_ENABLE   = 32'h0b000046;
    localparam logic [31:0] IDX_REQ_STATUS  = 32'h0b000048;
    localparam logic [31:0] IDX_IR_DIR      = 32'h0b00004a;

    localparam logic [31:0] ADDR_CTL_RESET  = IDX_CTL_RESET << 2;
    localparam logic [31:0] ADDR_SEQ_IDLE   = IDX_SEQ_IDLE << 2;
    localparam logic [31:0] ADDR_SEQ_ENABLE = IDX_SEQ_ENABLE << 2;
    localparam logic [31:0] ADDR_CH_ENABLE  = IDX_CH_ENABLE << 2;
    localparam logic [31:0] ADDR_REQ_STATUS = IDX_REQ_STATUS << 2;
    localparam logic [31:0] ADDR_IR_DIR     = IDX_IR_DIR << 2;

    // ------------------------------------------------------------------
    // Field positions within the 16-bit registers
    // ------------------------------------------------------------------
    localparam int BIT_CTL_RESET = 0;
    localparam int BIT_SEQ_EN    = 0;
    localparam int BIT_IDLE      = 0;
    localparam int BIT_AIN       = 3;
    localparam int BIT_AOUT      = 2;
    localparam int BIT_IR        = 0;
    localparam int BIT_IR_DIR    = 0;

    // ------------------------------------------------------------------
    // Reset values and channel numbering
    // ------------------------------------------------------------------
    localparam logic       RST_CTL_RESET = 1'b0;
    localparam logic       RST_SEQ_EN    = 1'b0;
    localparam logic [2:0] RST_CH_EN     = 3'h0;
    localparam logic       RST_IR_DIR    = 1'b0;
    localparam logic [2:0] RST_REQ       = 3'h0;

    localparam int NUM_CH  = 3;
    localparam int CH_AIN  = 2;     // Highest priority
    localparam int CH_AOUT = 1;
    localparam int CH_IR   = 0;     // Lowest priority

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Sequencer states, Gray along idle -> request -> transfer
    typedef enum logic [1:0] {
        DCR_IDLE = 2'h0,
        DCR_REQ  = 2'h1,
        DCR_XFER = 2'h3
    } dcr_state_t;

endpackage

// file: rtl/dcr_chan_gate.sv
// Per-channel eligibility gate for the DMA control register block
`timescale 1ns/1ns
module dcr_chan_gate
    import dcr_pkg::*;
(
    input  wire logic run,
    input  wire logic chan_enable,
    input  wire logic chan_request,
    output wire logic eligible
);
    // A channel competes only while running, enabled and requesting
    assign eligible = run & chan_enable & chan_request;
endmodule

// file: rtl/dcr_prio_arb.sv
// Fixed-priority arbiter, highest index wins
`timescale 1ns/1ns
module dcr_prio_arb
    import dcr_pkg::*;
#(
    parameter int N = NUM_CH
)
(
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] gnt
);
    // Refuse a width that leaves the arbiter with no requester
    if (N < 1) begin : g_bad_n
        $error("dcr_prio_arb needs at least one requester");
    end

    // Scan upward so the highest requesting index is the last to win
    always_comb begin
        gnt = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i]) begin
                gnt = '0;
                gnt[i] = 1'b1;
            end
        end
    end
endmodule

// file: rtl/dcr_top.sv
// DMA control registers and request sequencer behind an AHB-Lite slave
//
// Functional notes
// - Sequencer operates only while the sequencer enable bit is one.
// - Reserved bits are ignored on write and read back as zero.
// - Audio-input requests are picked at idle only while its channel enable bit is one.
// - Audio-output requests are picked at idle only while its channel enable bit is one.
// - Infrared requests are picked at idle only while its channel enable bit is one.
// - Read-only bit shows a pending audio-input request.
// - Read-only bit shows a pending audio-output request.
// - Read-only bit shows a pending infrared request.
// - Infrared direction bit one moves peripheral to memory, zero reverse.
// - Fixed priority: audio input, then audio output, then infrared.
// - Controller reset bit zero holds the sequencer in reset.
// - Read-only idle bit is one while the sequencer is idle.
`timescale 1ns/1ns
module dcr_top
    import dcr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Peripheral requests and acknowledges
    input  wire logic        audio_in_request,
    input  wire logic        audio_out_request,
    input  wire logic        ir_request,
    output logic             audio_in_ack,
    output logic             audio_out_ack,
    output logic             ir_ack,
    output logic             xfer_to_memory,
    // Bus control unit handshake
    output logic             bus_request,
    input  wire logic        bus_grant
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic             controller_reset_bit;
    logic             sequencer_enable_bit;
    logic             audio_in_channel_enable;
    logic             audio_out_channel_enable;
    logic             ir_channel_enable;
    logic             ir_direction_bit;
    logic [NUM_CH-1:0] req_seen;
    dcr_state_t       state;
    dcr_state_t       next_state;
    logic [NUM_CH-1:0] cur_ch;
    logic [NUM_CH-1:0] next_cur_ch;

    // ------------------------------------------------------------------
    // Bus pipeline state
    // ------------------------------------------------------------------
    logic        wr_pend;
    logic        rd_pend;
    logic [31:0] addr_q;

    // ------------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------------
    wire logic addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire logic take_wr   = addr_take & hwrite;
    wire logic take_rd   = addr_take & ~hwrite;

    // Data phase register selects from the held address
    wire logic sel_ctl   = (addr_q == ADDR_CTL_RESET);
    wire logic sel_idle  = (addr_q == ADDR_SEQ_IDLE);
    wire logic sel_seq   = (addr_q == ADDR_SEQ_ENABLE);
    wire logic sel_chen  = (addr_q == ADDR_CH_ENABLE);
    wire logic sel_req   = (addr_q == ADDR_REQ_STATUS);
    wire logic sel_dir   = (addr_q == ADDR_IR_DIR);

    wire logic wr_ctl    = wr_pend & sel_ctl;
    wire logic wr_seq    = wr_pend & sel_seq;
    wire logic wr_chen   = wr_pend & sel_chen;
    wire logic wr_dir    = wr_pend & sel_dir;

    // ------------------------------------------------------------------
    // Read words; only defined bits are placed, the rest stay zero
    // ------------------------------------------------------------------
    wire logic        seq_idle = (state == DCR_IDLE);
    logic [15:0] rd_ctl;
    logic [15:0] rd_idle;
    logic [15:0] rd_seq;
    logic [15:0] rd_chen;
    logic [15:0] rd_req;
    logic [15:0] rd_dir;

    always_comb begin
        rd_ctl  = 16'h0000;
        rd_idle = 16'h0000;
        rd_seq  = 16'h0000;
        rd_chen = 16'h0000;
        rd_req  = 16'h0000;
        rd_dir  = 16'h0000;
        rd_ctl[BIT_CTL_RESET] = controller_reset_bit;
        rd_idle[BIT_IDLE]     = seq_idle;
        rd_seq[BIT_SEQ_EN]    = sequencer_enable_bit;
        rd_chen[BIT_AIN]      = audio_in_channel_enable;
        rd_chen[BIT_AOUT]     = audio_out_channel_enable;
        rd_chen[BIT_IR]       = ir_channel_enable;
        rd_req[BIT_AIN]       = req_seen[CH_AIN];
        rd_req[BIT_AOUT]      = req_seen[CH_AOUT];
        rd_req[BIT_IR]        = req_seen[CH_IR];
        rd_dir[BIT_IR_DIR]    = ir_direction_bit;
    end

    // Unmapped addresses read as zero
    wire logic [15:0] rd_mux = sel_ctl  ? rd_ctl  :
                               sel_idle ? rd_idle :
                               sel_seq  ? rd_seq  :
                               sel_chen ? rd_chen :
                               sel_req  ? rd_req  :
                               sel_dir  ? rd_dir  : 16'h0000;

    // ------------------------------------------------------------------
    // AHB-Lite handshake: writes finish with no wait, reads take one
    // ------------------------------------------------------------------
    // The read wait state lets a write just ahead of it land first, so
    // read-after-write never returns a stale word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 32'h00000000;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end else if (ce) begin
            hresp <= 1'b0; // Always OKAY
            if (rd_pend) begin
                hrdata    <= {16'h0000, rd_mux};
                hreadyout <= 1'b1;
                rd_pend   <= 1'b0;
            end else begin
                wr_pend <= take_wr;
                rd_pend <= take_rd;
                if (addr_take) begin
                    addr_q <= haddr;
                end
                if (take_rd) begin
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Software-written control bits; reserved bits are dropped
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            controller_reset_bit     <= RST_CTL_RESET;
            sequencer_enable_bit     <= RST_SEQ_EN;
            audio_in_channel_enable  <= RST_CH_EN[CH_AIN];
            audio_out_channel_enable <= RST_CH_EN[CH_AOUT];
            ir_channel_enable        <= RST_CH_EN[CH_IR];
            ir_direction_bit         <= RST_IR_DIR;
        end else if (ce) begin
            if (wr_ctl) begin
                controller_reset_bit <= hwdata[BIT_CTL_RESET];
            end
            if (wr_seq) begin
                sequencer_enable_bit <= hwdata[BIT_SEQ_EN];
            end
            if (wr_chen) begin
                audio_in_channel_enable  <= hwdata[BIT_AIN];
                audio_out_channel_enable <= hwdata[BIT_AOUT];
                ir_channel_enable        <= hwdata[BIT_IR];
            end
            if (wr_dir) begin
                ir_direction_bit <= hwdata[BIT_IR_DIR];
            end
        end
    end

    // ------------------------------------------------------------------
    // Request capture: peripherals share hclk, so one register suffices
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_seen <= RST_REQ;
        end else if (ce) begin
            req_seen[CH_AIN]  <= audio_in_request;
            req_seen[CH_AOUT] <= audio_out_request;
            req_seen[CH_IR]   <= ir_request;
        end
    end

    // ------------------------------------------------------------------
    // Channel gating and priority
    // ------------------------------------------------------------------
    // Controller reset bit low acts as a held reset of the sequencer
    wire logic run = sequencer_enable_bit & controller_reset_bit;

    logic [NUM_CH-1:0] ch_enable;
    logic [NUM_CH-1:0] eligible;
    logic [NUM_CH-1:0] winner;

    assign ch_enable[CH_AIN]  = audio_in_channel_enable;
    assign ch_enable[CH_AOUT] = audio_out_channel_enable;
    assign ch_enable[CH_IR]   = ir_channel_enable;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_gate
        dcr_chan_gate u_gate (
            .run          (run),
            .chan_enable  (ch_enable[g]),
            .chan_request (req_seen[g]),
            .eligible     (eligible[g])
        );
    end

    dcr_prio_arb #(
        .N (NUM_CH)
    ) u_arb (
        .req (eligible),
        .gnt (winner)
    );

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    // Priority is fixed at the idle point; a later, higher request waits
    // for the next round rather than pre-empting a granted bus cycle.
    always_comb begin
        next_state  = state;
        next_cur_ch = cur_ch;
        unique case (state)
            DCR_IDLE: begin
                if (|eligible) begin
                    next_state  = DCR_REQ;
                    next_cur_ch = winner;
                end
            end
            DCR_REQ: begin
                if (!run) begin
                    next_state = DCR_IDLE;
                end else if (bus_grant) begin
                    next_state = DCR_XFER;
                end
            end
            DCR_XFER: begin
                next_state = DCR_IDLE;
            end
            default: begin
                next_state = DCR_IDLE;
            end
        endcase
    end

    // Direction of the transfer under way
    wire logic next_to_mem = next_cur_ch[CH_AIN] |
                             (next_cur_ch[CH_IR] & ir_direction_bit);

    wire logic to_xfer = (next_state == DCR_XFER) & (state != DCR_XFER);

    // ------------------------------------------------------------------
    // Sequencer registers and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state          <= DCR_IDLE;
            cur_ch         <= '0;
            bus_request    <= 1'b0;
            audio_in_ack   <= 1'b0;
            audio_out_ack  <= 1'b0;
            ir_ack         <= 1'b0;
            xfer_to_memory <= 1'b0;
        end else if (ce) begin
            if (!controller_reset_bit) begin
                state       <= DCR_IDLE;
                cur_ch      <= '0;
                bus_request <= 1'b0;
            end else begin
                state       <= next_state;
                cur_ch      <= next_cur_ch;
                bus_request <= (next_state == DCR_REQ);
            end
            // One-cycle acknowledge to the served unit
            audio_in_ack   <= controller_reset_bit & to_xfer & next_cur_ch[CH_AIN];
            audio_out_ack  <= controller_reset_bit & to_xfer & next_cur_ch[CH_AOUT];
            ir_ack         <= controller_reset_bit & to_xfer & next_cur_ch[CH_IR];
            xfer_to_memory <= next_to_mem;
        end
    end

    // Size is fixed at word; other sizes are served as word accesses
    wire logic unused_hsize = |hsize;

endmodule

// file: tb/dcr_checker.sv
// Port-level checker for the DMA control register block
`timescale 1ns/1ns
module dcr_checker
    import dcr_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        audio_in_request,
    input wire logic        audio_out_request,
    input wire logic        ir_request,
    input wire logic        audio_in_ack,
    input wire logic        audio_out_ack,
    input wire logic        ir_ack,
    input wire logic        xfer_to_memory,
    input wire logic        bus_request,
    input wire logic        bus_grant
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // Shadow of control bits
    // ----
    logic [31:0] a_q;
    logic        w_q, ctl, sen, dir;
    logic [3:0]  men;
    logic [2:0]  pick;
    wire         run  = ctl & sen;
    wire         ack  = audio_in_ack | audio_out_ack | ir_ack;
    wire  [2:0]  elig = {audio_in_request & men[3], audio_out_request & men[2],
                         ir_request & men[0]};
    // Snooped from bus writes; only valid while the clock enable stays high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {a_q, w_q, ctl, sen, dir, men, pick} <= '0;
        end else begin
            a_q <= haddr;
            w_q <= hsel & hready & hwrite & (htrans == HTRANS_NONSEQ);
            if (w_q && a_q == ADDR_CTL_RESET) ctl <= hwdata[0];
            if (w_q && a_q == ADDR_SEQ_ENABLE) sen <= hwdata[0];
            if (w_q && a_q == ADDR_CH_ENABLE) men <= hwdata[3:0];
            if (w_q && a_q == ADDR_IR_DIR) dir <= hwdata[0];
            if ($rose(bus_request)) pick <= $past(elig, 2);
        end
    end
    // Sequencer handshake steps
    sequence s_ack; ack; endsequence
    sequence s_grant; bus_request && bus_grant && run; endsequence
    property p_run_gate; !run |=> !bus_request; endproperty
    a_run_gate: assert property (p_run_gate) else $error("bus request while stopped");
    property p_chan_en; s_ack |-> (!audio_in_ack || men[3]) && (!audio_out_ack || men[2])
        && (!ir_ack || men[0]); endproperty
    a_chan_en: assert property (p_chan_en) else $error("ack on disabled channel");
    property p_ir_dir; ir_ack |-> xfer_to_memory == dir; endproperty
    a_ir_dir: assert property (p_ir_dir) else $error("wrong ir direction");
    property p_prio; s_ack |-> (audio_in_ack || !pick[2]) && (!ir_ack || !pick[1]); endproperty
    a_prio: assert property (p_prio) else $error("lower channel served first");
    property p_grant_ack; s_grant |=> s_ack; endproperty
    a_grant_ack: assert property (p_grant_ack) else $error("no ack after grant");
    property p_ack_cause; s_ack |-> $past(bus_request) && $past(bus_grant); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without grant");
    property p_ack_pulse; s_ack |-> !bus_request ##1 !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");
    property p_req_cause; $rose(bus_request) |-> $past(run) && $past(elig, 2) != 3'h0; endproperty
    a_req_cause: assert property (p_req_cause) else $error("bus request without cause");
endmodule
bind dcr_top dcr_checker i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .audio_in_request(audio_in_request),
    .audio_out_request(audio_out_request), .ir_request(ir_request), .ir_ack(ir_ack),
    .audio_in_ack(audio_in_ack), .audio_out_ack(audio_out_ack),
    .xfer_to_memory(xfer_to_memory), .bus_request(bus_request), .bus_grant(bus_grant)
);

// file: tb/dcr_periph_model.sv
// Peripheral request sources and bus arbiter facing the sequencer
`timescale 1ns/1ns
module dcr_periph_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] raise,
    input  wire logic       clr,
    input  wire logic [3:0] gnt_dly,
    input  wire logic [2:0] ack,
    input  wire logic       bus_request,
    output logic      [2:0] req,
    output logic      [2:0] pend,
    output logic            bus_grant
);
    logic [3:0] cnt;
    // Request drops in the ack cycle so one request is served once
    assign req = pend & ~ack;
    // Grant after a set delay, only while the bus is asked for
    assign bus_grant = bus_request && cnt >= gnt_dly;
    // Pending flags and arbiter wait counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 3'h0;
            cnt  <= 4'h0;
        end else begin
            pend <= clr ? 3'h0 : (pend | raise) & ~ack;
            cnt  <= bus_request ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// file: tb/dma_control_registers_tb_top.sv
// Self-checking bench for the DMA control register block
`timescale 1ns/1ns
module dma_control_registers_tb_top import dcr_pkg::*; ;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr = 1'b0;
    logic        rd_dp = 1'b0, dir = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, raise = 3'h0, ack_q[$];
    logic [3:0]  gnt_dly = 4'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, exp_q[$];
    wire  [31:0] hrdata;
    wire  [2:0]  req, pend;
    wire         hready, hresp, ain_ack, aout_ack, ir_ack, xfer, bus_request, bus_grant;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0;
    logic [31:0] adr[7] = '{ADDR_CTL_RESET, ADDR_SEQ_IDLE, ADDR_SEQ_ENABLE, ADDR_CH_ENABLE,
                           ADDR_REQ_STATUS, ADDR_IR_DIR, ADDR_IR_DIR + 32'h8};
    logic [31:0] msk[7] = '{32'h1, 32'h0, 32'h1, 32'hd, 32'h0, 32'h1, 32'h0};
    dcr_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .audio_in_request(req[2]),
        .audio_out_request(req[1]), .ir_request(req[0]), .audio_in_ack(ain_ack),
        .audio_out_ack(aout_ack), .ir_ack(ir_ack), .xfer_to_memory(xfer),
        .bus_request(bus_request), .bus_grant(bus_grant)
    );
    dcr_periph_model i_peri (
        .hclk(hclk), .hresetn(hresetn), .raise(raise), .clr(clr), .gnt_dly(gnt_dly),
        .ack({ain_ack, aout_ack, ir_ack}), .bus_request(bus_request), .req(req),
        .pend(pend), .bus_grant(bus_grant)
    );
    // ----
    // Clock, hang limit, shared tasks
    // ----
    always #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Single word transfer; a read notes its expected data first
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        if (!w) exp_q.push_back(d);
        htrans <= HTRANS_NONSEQ;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
    endtask
    task automatic pulse(input logic [2:0] v, input logic c);
        raise <= v;
        clr <= c;
        @(posedge hclk);
        raise <= 3'h0;
        clr <= 1'b0;
    endtask
    // Results are compared against the oldest note as they appear
    always @(posedge hclk) begin
        if (rd_dp && hready) begin
            check(hrdata, exp_q.pop_front(), "read");
            check(hresp, 1'b0, "response");
            rd_dp = 1'b0;
        end
        if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) rd_dp = 1'b1;
        if (ain_ack | aout_ack | ir_ack) begin
            if (ack_q.size() == 0) ack_q.push_back(3'h0);
            check({ain_ack, aout_ack, ir_ack}, ack_q.pop_front(), "ack");
            if (ir_ack) check(xfer, dir, "direction");
        end
    end
    initial begin
        int k;
        logic [31:0] r;
        r = $urandom(68024);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (k = 0; k < 7; k++) bus(1'b0, adr[k], {31'h0, k == 1});
        $display("reset values done");
        for (k = 0; k < 7; k++) begin
            r = $urandom;
            bus(1'b1, adr[k], r & msk[k]);
            bus(1'b0, adr[k], (r & msk[k]) | {31'h0, k == 1});
        end
        $display("reserved bits done");
        bus(1'b1, ADDR_CTL_RESET, 32'h1);
        bus(1'b1, ADDR_CH_ENABLE, 32'hd);
        // Requests wait while stopped, then go in fixed order
        for (k = 0; k < 2; k++) begin
            dir = k[0];
            bus(1'b1, ADDR_IR_DIR, {31'h0, dir});
            bus(1'b1, ADDR_SEQ_ENABLE, 32'h0);
            pulse(3'h7, 1'b0);
            repeat (8) @(posedge hclk);
            check(bus_request, 1'b0, "stopped");
            bus(1'b0, ADDR_REQ_STATUS, 32'hd);
            gnt_dly <= 4'($urandom_range(3));
            ack_q = '{3'h4, 3'h2, 3'h1};
            bus(1'b1, ADDR_SEQ_ENABLE, 32'h1);
            for (r = 0; r < 60 && pend != 3'h0; r++) @(posedge hclk);
            bus(1'b0, ADDR_REQ_STATUS, 32'h0);
        end
        $display("priority done");
        // One channel enabled at a time, the others left waiting
        for (k = 0; k < 3; k++) begin
            r = (k == 2) ? 32'h1 : 32'h8 >> k;
            bus(1'b1, ADDR_CH_ENABLE, r);
            ack_q.push_back(3'h4 >> k);
            pulse(3'h7, 1'b0);
            repeat (12) @(posedge hclk);
            bus(1'b0, ADDR_REQ_STATUS, 32'hd & ~r);
            pulse(3'h0, 1'b1);
        end
        $display("channel enables done");
        // Controller reset dropped while a request waits for the bus
        bus(1'b1, ADDR_CH_ENABLE, 32'hd);
        gnt_dly <= 4'hf;
        pulse(3'h1, 1'b0);
        for (k = 0; k < 20 && !bus_request; k++) @(posedge hclk);
        bus(1'b0, ADDR_SEQ_IDLE, 32'h0);
        bus(1'b1, ADDR_CTL_RESET, 32'h0);
        repeat (20) @(posedge hclk);
        check(bus_request, 1'b0, "held in reset");
        bus(1'b0, ADDR_SEQ_IDLE, 32'h1);
        $display("abort done");
        stop_test();
    end
endmodule
